/* rtl/aodp_pkg.sv */
package aodp_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_CNT_W = 17;
	localparam int RELAY_SETTLE_US = 10;
	localparam int RELAY_SETTLE_CYC =
		(RELAY_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 10;

	// apb register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ANGLE = 8'h04;
	localparam logic [7:0] OFF_VOLT = 8'h08;
	localparam logic [7:0] OFF_DROP = 8'h0C;
	localparam logic [7:0] OFF_DISP = 8'h10;
	localparam logic [7:0] OFF_CURRENT_LIMIT_QUERY = 8'h14;
	localparam logic [7:0] OFF_LIM_FLO = 8'h18;
	localparam logic [7:0] OFF_LIM_FHI = 8'h1C;
	localparam logic [7:0] OFF_VOLTAGE_CEILING_QUERY = 8'h20;
	localparam logic [7:0] OFF_FREQ = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;
	localparam logic [7:0] OFF_MASK = 8'h2C;

	// field positions
	localparam int CTRL_RELAY_BIT = 0;
	localparam int CTRL_PHEN_BIT = 1;
	localparam int DROP_INDEF_BIT = 31;
	localparam int DROP_ACTIVE_BIT = 0;
	localparam int DUR_W = 22;
	localparam int VAL_W = 16;
	localparam int ANG_W = 9;

	// status / mask bits
	localparam int ST_W = 5;
	localparam int ST_SYNTAX = 0;
	localparam int ST_CMDERR = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_DROPDONE = 3;
	localparam int ST_VOLTAPPL = 4;

	// drop duration limits and step boundaries, in ms
	localparam logic [DUR_W-1:0] DUR_MIN = 22'h00_0001;
	localparam logic [DUR_W-1:0] DUR_MAX = 22'h3D_0900;
	localparam logic [DUR_W-1:0] DUR_B10S = 22'h00_2710;
	localparam logic [DUR_W-1:0] DUR_B100S = 22'h01_86A0;
	localparam logic [DUR_W-1:0] DUR_B1000S = 22'h0F_4240;
	localparam logic [DUR_W-1:0] STEP_10 = 22'h00_000A;
	localparam logic [DUR_W-1:0] STEP_100 = 22'h00_0064;
	localparam logic [DUR_W-1:0] STEP_1000 = 22'h00_03E8;

	// start phase angles in degrees
	localparam logic [ANG_W-1:0] DEG_0 = 9'h000;
	localparam logic [ANG_W-1:0] DEG_90 = 9'h05A;
	localparam logic [ANG_W-1:0] DEG_180 = 9'h0B4;
	localparam logic [ANG_W-1:0] DEG_270 = 9'h10E;

	// display codes
	localparam logic [2:0] DISP_FREQ = 3'h1;
	localparam logic [2:0] DISP_PF = 3'h5;

	typedef enum logic [1:0] {
		REL_IDLE = 2'b00,
		REL_OPENING = 2'b01,
		REL_CLOSING = 2'b10
	} aodp_relay_t;

	// keep four significant digits of a duration in ms
	function automatic logic [DUR_W-1:0] quantDur(input logic [DUR_W-1:0] ms);
		if (ms < DUR_B10S)
			quantDur = ms;
		else if (ms < DUR_B100S)
			quantDur = ms - (ms % STEP_10);
		else if (ms < DUR_B1000S)
			quantDur = ms - (ms % STEP_100);
		else
			quantDur = ms - (ms % STEP_1000);
	endfunction : quantDur

	function automatic logic [1:0] angleCode(input logic [ANG_W-1:0] deg);
		unique case (deg)
			DEG_90: angleCode = 2'h1;
			DEG_180: angleCode = 2'h2;
			DEG_270: angleCode = 2'h3;
			default: angleCode = 2'h0;
		endcase
	endfunction : angleCode

	function automatic logic angleOk(input logic [ANG_W-1:0] deg);
		angleOk = (deg == DEG_0) || (deg == DEG_90) ||
			(deg == DEG_180) || (deg == DEG_270);
	endfunction : angleOk
endpackage : aodp_pkg

/* rtl/aodp_phase_gate.sv */
`timescale 1ns/10ps
`default_nettype none
module aodp_phase_gate
	import aodp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// gating setup
	input wire logic enable,
	input wire logic [1:0] angle,
	input wire logic [1:0] quadrant,
	input wire logic pending,
	// release
	output logic fire
);
	typedef struct packed {
		logic [1:0] prevQuad;
	} aodp_gate_st_t;

	aodp_gate_st_t st;
	aodp_gate_st_t next_st;
	logic atAngle;

	always_comb begin
		next_st = st;
		next_st.prevQuad = quadrant;
		atAngle = (quadrant != st.prevQuad) && (quadrant == angle); // [RULE8]
		fire = pending && (!enable || atAngle); // [RULE7] [RULE10]
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end
endmodule : aodp_phase_gate
`default_nettype wire

/* rtl/aodp_drop_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module aodp_drop_timer
	import aodp_pkg::*;
#(
	parameter logic [MS_CNT_W-1:0] TICK_CYCLES = MS_CNT_W'(MS_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic start,
	input wire logic [DUR_W-1:0] durMs,
	input wire logic abort,
	// state
	output logic active,
	output logic done
);
	typedef struct packed {
		logic [MS_CNT_W-1:0] tickCnt;
		logic [DUR_W-1:0] remaining;
		logic active;
		logic done;
	} aodp_tmr_st_t;

	aodp_tmr_st_t st;
	aodp_tmr_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			next_st.active = 1'b1;
			next_st.remaining = durMs;
			next_st.tickCnt = TICK_CYCLES - 1'b1;
		end else if (abort) begin
			next_st.active = 1'b0;
		end else if (st.active) begin
			// one millisecond tick
			if (st.tickCnt == '0) begin // [RULE18]
				next_st.tickCnt = TICK_CYCLES - 1'b1;
				if (st.remaining == DUR_MIN) begin // [RULE3]
					next_st.active = 1'b0;
					next_st.done = 1'b1;
				end
				next_st.remaining = st.remaining - 1'b1;
			end else begin
				next_st.tickCnt = st.tickCnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign active = st.active;
	assign done = st.done;
endmodule : aodp_drop_timer
`default_nettype wire

/* rtl/aodp_top.sv */
//Contract
//[RULE1] zero the voltage before opening relay; restore it after closing
//[RULE2] relay takes 1 close, 0 open; reset from power-on setting; readable
//[RULE3] drop cuts output electronically, relay closed, 1 ms to 4000 s
//[RULE4] drop duration keeps four significant digits, step grows per decade
//[RULE5] drop without duration lasts until next voltage command
//[RULE6] drop status reads 1 while in progress, 0 once expired
//[RULE7] phase-start off (reset) applies drops and voltage at once
//[RULE8] phase-start on delays drops and voltage to the start angle
//[RULE9] angle only 0, 90, 180, 270, reset 0; others are a syntax error
//[RULE10] stored angle used only while phase-start mode is on
//[RULE11] limit values are read-only; writes refused
//[RULE12] current limit reads maximum current in low voltage range
//[RULE13] fixed frequency: equal limits, other frequency is command error
//[RULE14] voltage limit below 201 single range, above 200 dual range
//[RULE15] dual range limit even, low range is half
//[RULE16] display select codes 1 to 5, reset 1
//[RULE17] host sequence: zero volts, close, enable, angle, drop, then volts
//[RULE18] drop timer ticks in ms, starts once phase gate released
`timescale 1ns/10ps
`default_nettype none
module aodp_top
	import aodp_pkg::*;
#(
	parameter logic [MS_CNT_W-1:0] TICK_CYCLES = MS_CNT_W'(MS_CYCLES),
	parameter logic [VAL_W-1:0] CURRENT_LIMIT_QUERY_VAL = 16'h03E8,
	parameter logic [VAL_W-1:0] LIM_FLO_VAL = 16'h01C2,
	parameter logic [VAL_W-1:0] LIM_FHI_VAL = 16'h1388,
	parameter logic [VAL_W-1:0] VOLTAGE_CEILING_QUERY_VAL = 16'h012C
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power-on relay setting, waveform quadrant
	input wire logic ponRelay,
	input wire logic [1:0] waveQuadrant,
	// output control
	output logic relayClose,
	output logic [VAL_W-1:0] outVoltage,
	output logic outputDrop,
	output logic [VAL_W-1:0] outFreq,
	output logic [2:0] displaySelect,
	output logic irq
);
	typedef struct packed {
		// apb answer
		logic ready;
		logic slvErr;
		logic [31:0] rdata;

		// power-on relay synchroniser
		logic ponMeta;
		logic ponSync;
		logic ponLoad;

		// relay sequencing
		logic relayCmd;
		logic relayOut;
		aodp_relay_t relayState;
		logic [SETTLE_W-1:0] settleCnt;

		// programmed and applied voltage
		logic [VAL_W-1:0] progVolt;
		logic [VAL_W-1:0] applVolt;

		// phase gating and drops
		logic phaseEn;
		logic [ANG_W-1:0] angleDeg;
		logic pendDrop;
		logic pendIndef;
		logic [DUR_W-1:0] pendDur;
		logic pendVolt;
		logic indefDrop;
		logic dropOut;

		// settings, status and interrupt
		logic [VAL_W-1:0] freq;
		logic [2:0] dispMode;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic irq;
	} aodp_st_t;

	aodp_st_t st;
	aodp_st_t next_st;

	// sub-block handshakes
	logic gateFire;
	logic timerActive;
	logic timerDone;
	logic timerStart;
	logic timerAbort;

	// bus decode
	logic apbAccess;
	logic apbWrite;
	logic mapped;
	logic [ST_W-1:0] events;
	logic [DUR_W-1:0] wrDur;
	logic [31:0] readMux;

	function automatic logic isLimit(input logic [ADDR_W-1:0] a);
		isLimit = (a == OFF_CURRENT_LIMIT_QUERY) || (a == OFF_LIM_FLO) ||
			(a == OFF_LIM_FHI) || (a == OFF_VOLTAGE_CEILING_QUERY);
	endfunction : isLimit

	// start angle decoded to a quadrant
	aodp_phase_gate u_gate (
		.clk(clk),
		.sys_rst(sys_rst),
		.enable(st.phaseEn),
		.angle(angleCode(st.angleDeg)),
		.quadrant(waveQuadrant),
		.pending(st.pendDrop || st.pendVolt),
		.fire(gateFire)
	);

	// timed drop counter
	aodp_drop_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(timerStart),
		.durMs(st.pendDur),
		.abort(timerAbort),
		.active(timerActive),
		.done(timerDone)
	);

	always_comb begin
		mapped = 1'b1;
		readMux = '0;
		unique case (paddr)
			OFF_CTRL: begin
				readMux[CTRL_RELAY_BIT] = st.relayCmd; // [RULE2]
				readMux[CTRL_PHEN_BIT] = st.phaseEn;
			end

			OFF_ANGLE: readMux[ANG_W-1:0] = st.angleDeg;
			OFF_VOLT: readMux[VAL_W-1:0] = st.progVolt;
			OFF_DROP: readMux[DROP_ACTIVE_BIT] = st.dropOut || st.pendDrop; // [RULE6]
			OFF_DISP: readMux[2:0] = st.dispMode;

			OFF_CURRENT_LIMIT_QUERY: readMux[VAL_W-1:0] = CURRENT_LIMIT_QUERY_VAL; // [RULE12]
			OFF_LIM_FLO: readMux[VAL_W-1:0] = LIM_FLO_VAL; // [RULE13]
			OFF_LIM_FHI: readMux[VAL_W-1:0] = LIM_FHI_VAL; // [RULE13]
			OFF_VOLTAGE_CEILING_QUERY: readMux[VAL_W-1:0] = VOLTAGE_CEILING_QUERY_VAL; // [RULE14] [RULE15]

			OFF_FREQ: readMux[VAL_W-1:0] = st.freq;
			OFF_STATUS: readMux[ST_W-1:0] = st.status;
			OFF_MASK: readMux[ST_W-1:0] = st.mask;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		events = '0;
		timerStart = 1'b0;
		timerAbort = 1'b0;
		wrDur = pwdata[DUR_W-1:0];
		apbAccess = psel && penable && st.ready;
		apbWrite = apbAccess && pwrite;

		// power-on relay setting, synchronised then loaded once
		next_st.ponMeta = ponRelay;
		next_st.ponSync = st.ponMeta;
		next_st.ponLoad = 1'b0;
		if (st.ponLoad)
			next_st.relayCmd = st.ponSync; // [RULE2]

		// apb: one wait state, data and error registered
		next_st.ready = psel && penable && !st.ready;
		if (psel && penable && !st.ready) begin
			next_st.rdata = readMux;
			next_st.slvErr = !mapped || (pwrite && isLimit(paddr)); // [RULE11]
		end

		if (apbWrite) begin
			unique case (paddr)
				OFF_CTRL: begin
					next_st.relayCmd = pwdata[CTRL_RELAY_BIT]; // [RULE2]
					next_st.phaseEn = pwdata[CTRL_PHEN_BIT];
				end

				OFF_ANGLE: begin
					if (angleOk(pwdata[ANG_W-1:0]) && pwdata[31:ANG_W] == '0)
						next_st.angleDeg = pwdata[ANG_W-1:0]; // [RULE9]
					else
						events[ST_SYNTAX] = 1'b1; // [RULE9]
				end

				OFF_VOLT: begin
					next_st.progVolt = pwdata[VAL_W-1:0];
					next_st.pendVolt = 1'b1;
				end

				OFF_DROP: begin
					if (pwdata[DROP_INDEF_BIT]) begin
						next_st.pendDrop = 1'b1;
						next_st.pendIndef = 1'b1; // [RULE5]
					end else if (wrDur >= DUR_MIN && wrDur <= DUR_MAX &&
						pwdata[DROP_INDEF_BIT-1:DUR_W] == '0) begin // [RULE3]
						next_st.pendDrop = 1'b1;
						next_st.pendIndef = 1'b0;
						next_st.pendDur = quantDur(wrDur); // [RULE4]
					end else begin
						events[ST_SYNTAX] = 1'b1;
					end
				end

				OFF_DISP: begin
					if (pwdata[2:0] >= DISP_FREQ && pwdata[2:0] <= DISP_PF &&
						pwdata[31:3] == '0)
						next_st.dispMode = pwdata[2:0]; // [RULE16]
					else
						events[ST_SYNTAX] = 1'b1;
				end

				OFF_FREQ: begin
					if (pwdata[VAL_W-1:0] >= LIM_FLO_VAL &&
						pwdata[VAL_W-1:0] <= LIM_FHI_VAL && pwdata[31:VAL_W] == '0)
						next_st.freq = pwdata[VAL_W-1:0];
					else
						events[ST_CMDERR] = 1'b1; // [RULE13]
				end

				OFF_CURRENT_LIMIT_QUERY, OFF_LIM_FLO, OFF_LIM_FHI, OFF_VOLTAGE_CEILING_QUERY:
					events[ST_REFUSED] = 1'b1; // [RULE11]

				OFF_STATUS: next_st.status = st.status & ~pwdata[ST_W-1:0];

				OFF_MASK: next_st.mask = pwdata[ST_W-1:0];

				default: ;
			endcase
		end

		// phase-gated release of drops and voltage changes
		if (gateFire) begin // [RULE7] [RULE8]
			if (st.pendDrop) begin
				next_st.pendDrop = 1'b0;
				if (st.pendIndef) begin
					next_st.indefDrop = 1'b1; // [RULE5]
					timerAbort = 1'b1;
				end else begin
					next_st.indefDrop = 1'b0;
					timerStart = 1'b1; // [RULE18]
				end
			end

			if (st.pendVolt && !(apbWrite && paddr == OFF_VOLT)) begin
				next_st.pendVolt = 1'b0;
				events[ST_VOLTAPPL] = 1'b1;
				if (st.relayOut && st.relayState == REL_IDLE)
					next_st.applVolt = st.progVolt;
				if (!(st.pendDrop && st.pendIndef))
					next_st.indefDrop = 1'b0; // [RULE5]
			end
		end

		next_st.dropOut = timerActive || next_st.indefDrop; // [RULE3]
		if (timerDone)
			events[ST_DROPDONE] = 1'b1; // [RULE6]

		// relay with voltage forced to zero around switching
		unique case (st.relayState)
			REL_IDLE: begin
				if (st.relayCmd != st.relayOut) begin
					next_st.settleCnt = SETTLE_W'(RELAY_SETTLE_CYC);
					if (st.relayCmd) begin
						next_st.relayOut = 1'b1;
						next_st.relayState = REL_CLOSING;
					end else begin
						next_st.applVolt = '0; // [RULE1]
						next_st.relayState = REL_OPENING;
					end
				end
			end

			REL_OPENING: begin
				next_st.settleCnt = st.settleCnt - 1'b1;
				if (st.settleCnt == '0) begin
					next_st.relayOut = 1'b0; // [RULE1]
					next_st.relayState = REL_IDLE;
				end
			end

			REL_CLOSING: begin
				next_st.settleCnt = st.settleCnt - 1'b1;
				if (st.settleCnt == '0) begin
					next_st.applVolt = st.progVolt; // [RULE1]
					next_st.relayState = REL_IDLE;
				end
			end

			default: next_st.relayState = REL_IDLE;
		endcase

		// sticky status, set wins over clear
		next_st.status = next_st.status | events;
		next_st.irq = |(next_st.status & next_st.mask);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.ponLoad <= 1'b1;
			// synchroniser keeps sampling in reset for the first load
			st.ponMeta <= ponRelay; // [RULE2]
			st.ponSync <= st.ponMeta;
			st.angleDeg <= DEG_0; // [RULE9]
			st.phaseEn <= 1'b0; // [RULE7]
			st.dispMode <= DISP_FREQ; // [RULE16]
			st.freq <= LIM_FLO_VAL;
			st.relayState <= REL_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = st.ready;
	assign pslverr = st.slvErr;
	assign relayClose = st.relayOut;
	assign outVoltage = st.applVolt;
	assign outputDrop = st.dropOut;
	assign outFreq = st.freq;
	assign displaySelect = st.dispMode;
	assign irq = st.irq;
endmodule : aodp_top
`default_nettype wire

/* tb/aodp_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module aodp_properties
	import aodp_pkg::*;
#(
	parameter logic [MS_CNT_W-1:0] TICK_CYCLES = MS_CNT_W'(MS_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic ponRelay,
	input wire logic [1:0] waveQuadrant,
	input wire logic relayClose,
	input wire logic [VAL_W-1:0] outVoltage,
	input wire logic outputDrop,
	input wire logic [VAL_W-1:0] outFreq,
	input wire logic [2:0] displaySelect,
	input wire logic irq
);
	logic done, phEn, indef, voltSeen;
	logic [1:0] angQ;
	logic [ST_W-1:0] maskQ;
	logic [DUR_W-1:0] durRaw;
	logic [31:0] dropLen, expLen;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	assign done = psel && penable && pready;
	assign expLen = 32'(durRaw) * 32'(TICK_CYCLES);
	// mirror of the settings the assertions depend on
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phEn <= 1'b0;
			indef <= 1'b0;
			voltSeen <= 1'b0;
			angQ <= 2'h0;
			maskQ <= '0;
			durRaw <= '0;
		end else if (done && pwrite) begin
			if (paddr == OFF_CTRL)
				phEn <= pwdata[CTRL_PHEN_BIT];
			if (paddr == OFF_ANGLE && pwdata[ANG_W-1:0] % 9'd90 == 9'd0
				&& pwdata[ANG_W-1:0] < 9'd360)
				angQ <= 2'(pwdata[ANG_W-1:0] / 9'd90);
			if (paddr == OFF_MASK)
				maskQ <= pwdata[ST_W-1:0];
			if (paddr == OFF_VOLT)
				voltSeen <= 1'b1;
			if (paddr == OFF_DROP) begin
				indef <= pwdata[DROP_INDEF_BIT];
				durRaw <= pwdata[DUR_W-1:0];
				voltSeen <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk) begin
		dropLen <= (outputDrop && !sys_rst) ? dropLen + 32'h0000_0001 : '0;
	end
	sequence dropWr_s;
		done && pwrite && paddr == OFF_DROP;
	endsequence
	sequence dropRd_s;
		done && !pwrite && paddr == OFF_DROP;
	endsequence
	zero_when_open_a: assert property (outVoltage != '0 |-> relayClose)
		else $error("output live with relay open");
	close_quiet_a: assert property ($rose(relayClose) |-> (outVoltage == '0)[*8])
		else $error("voltage restored too early");
	limit_ro_a: assert property (done && pwrite && paddr >= OFF_CURRENT_LIMIT_QUERY
		&& paddr <= OFF_VOLTAGE_CEILING_QUERY |-> pslverr) else $error("limit write taken");
	disp_range_a: assert property (displaySelect >= 3'h1 && displaySelect <= 3'h5)
		else $error("display code out of range");
	drop_now_a: assert property (dropWr_s ##0 (!phEn && (pwdata[DROP_INDEF_BIT]
		|| pwdata[DUR_W-1:0] inside {[DUR_MIN:DUR_MAX]})) |-> ##[1:3] outputDrop)
		else $error("ungated drop late");
	phase_gate_a: assert property ($rose(outputDrop) && phEn
		|-> $past(waveQuadrant) == angQ) else $error("drop off start angle");
	indef_hold_a: assert property ($fell(outputDrop) && indef |-> voltSeen)
		else $error("indefinite drop ended alone");
	drop_len_a: assert property ($fell(outputDrop) && !indef && durRaw < DUR_B10S
		|-> dropLen + 1 >= expLen && dropLen <= expLen + 1)
		else $error("timed drop length wrong");
	drop_status_a: assert property (dropRd_s ##0 (outputDrop
		&& $past(outputDrop)) |-> prdata[DROP_ACTIVE_BIT]) else $error("drop status low");
	irq_mask_a: assert property ((maskQ == '0)[*3] |-> !irq)
		else $error("interrupt while masked");
	apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("wait state wrong");
endmodule : aodp_properties
`default_nettype wire

/* tb/aodp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module aodp_host_model
	import aodp_pkg::*;
(
	// clock
	input wire logic clk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	// slave answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// one transfer, held until pready is sampled high or 64 cycles pass
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		r = (pready === 1'b1) ? prdata : 'x;
		e = (pready === 1'b1) ? pslverr : 1'bx;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
endmodule : aodp_host_model
`default_nettype wire

/* tb/tb_aodp_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_aodp_top
	import aodp_pkg::*;
;
	localparam logic [VAL_W-1:0] FIXF = 16'h0032;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, v, lims [4];
	logic ponRelay = 1'b0;
	logic [1:0] waveQuadrant = 2'h0;
	logic relayClose, outputDrop, irq;
	logic [VAL_W-1:0] outVoltage, outFreq;
	logic [2:0] displaySelect;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 32'he2fc;
	int k, n;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 8 == 7)
			waveQuadrant <= waveQuadrant + 2'h1;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end
	aodp_host_model u_aodp_host_model (.clk(clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	aodp_top #(.TICK_CYCLES(17'h0_0001), .LIM_FLO_VAL(FIXF),
		.LIM_FHI_VAL(FIXF)) u_aodp_top (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ponRelay(ponRelay), .waveQuadrant(waveQuadrant),
		.relayClose(relayClose), .outVoltage(outVoltage),
		.outputDrop(outputDrop), .outFreq(outFreq),
		.displaySelect(displaySelect), .irq(irq));
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] sn);
		n_tests++;
		if (sn !== ex) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_aodp_host_model.xfer(1'b1, a, d, rd, err);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] ex);
		u_aodp_host_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
		chk(nm, ex, rd);
	endtask : rdchk
	task automatic waitFor(input logic lvl);
		n = 0;
		while (outputDrop !== lvl && n < 20000) begin
			@(posedge clk);
			n++;
		end
	endtask : waitFor
	task automatic final_report();
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	initial begin
		lims = '{32'h0000_03E8, 32'(FIXF), 32'(FIXF), 32'h0000_012C};
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		chk("display reset", 32'h1, 32'(displaySelect));
		rdchk("ctrl reset", OFF_CTRL, 32'h0);
		rdchk("angle reset", OFF_ANGLE, 32'h0);
		rdchk("drop idle", OFF_DROP, 32'h0);
		u_aodp_host_model.xfer(1'b0, 8'h30, 32'h0, rd, err);
		chk("unmapped err", 32'h1, 32'(err));
		for (k = 0; k < 4; k++) begin
			wr(OFF_CURRENT_LIMIT_QUERY + 8'(4 * k), 32'h0000_FFFF);
			chk("limit err", 32'h1, 32'(err));
			rdchk("limit", OFF_CURRENT_LIMIT_QUERY + 8'(4 * k), lims[k]);
		end
		wr(OFF_FREQ, 32'(FIXF) + 32'h1);
		wr(OFF_FREQ, 32'(FIXF));
		chk("freq", 32'(FIXF), 32'(outFreq));
		rdchk("status", OFF_STATUS, 32'h0000_0006);
		wr(OFF_STATUS, 32'h0000_001F);
		for (k = 0; k < 8; k++) begin
			v = (k < 4) ? 32'(90 * k) : ($random(seed) & 32'h1FE) | 32'h1;
			wr(OFF_ANGLE, v);
			rdchk("angle", OFF_ANGLE, (k < 4) ? v : 32'h0000_010E);
		end
		rdchk("syntax", OFF_STATUS, 32'h0000_0001);
		for (k = 0; k < 8; k++) begin
			wr(OFF_DISP, 32'(k));
			@(posedge clk);
			chk("display", (k > 5) ? 5 : (k == 0) ? 1 : k, 32'(displaySelect));
		end
		wr(OFF_CTRL, 32'h1);
		repeat (1100) @(posedge clk);
		rdchk("relay cmd", OFF_CTRL, 32'h1);
		v = 32'(1 + $unsigned($random(seed)) % 300);
		wr(OFF_VOLT, v);
		repeat (4) @(posedge clk);
		chk("volt now", v, 32'(outVoltage));
		wr(OFF_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk("volt off first", 32'h1, 32'({relayClose, outVoltage} == 17'h1_0000));
		repeat (1100) @(posedge clk);
		chk("relay open", 32'h0, 32'(relayClose));
		wr(OFF_CTRL, 32'h1);
		repeat (1100) @(posedge clk);
		chk("volt back", v, 32'(outVoltage));
		wr(OFF_MASK, 32'h0000_0008);
		wr(OFF_DROP, 32'(20 + $unsigned($random(seed)) % 40));
		rdchk("drop busy", OFF_DROP, 32'h1);
		waitFor(1'b0);
		repeat (3) @(posedge clk);
		rdchk("drop over", OFF_DROP, 32'h0);
		chk("irq up", 32'h1, 32'(irq));
		wr(OFF_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq masked", 32'h0, 32'(irq));
		wr(OFF_MASK, 32'h0000_0008);
		wr(OFF_STATUS, 32'h0000_0008);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, 32'(irq));
		wr(OFF_DROP, 32'h0000_2719);
		waitFor(1'b1);
		waitFor(1'b0);
		chk("quantised", 32'h1, 32'(n >= 9998 && n <= 10002));
		wr(OFF_VOLT, 32'h0);
		wr(OFF_CTRL, 32'h3);
		wr(OFF_ANGLE, 32'h0000_005A);
		wr(OFF_DROP, 32'h8000_0000);
		waitFor(1'b1);
		chk("drop angle", 32'h1, 32'(waveQuadrant));
		repeat (100) @(posedge clk);
		chk("drop held", 32'h1, 32'(outputDrop));
		wr(OFF_VOLT, v);
		waitFor(1'b0);
		@(posedge clk);
		chk("volt angle", 32'h1, 32'(waveQuadrant));
		chk("volt on", v, 32'(outVoltage));
		wr(OFF_CTRL, 32'h1);
		wr(OFF_DROP, 32'h8000_0000);
		repeat (3) @(posedge clk);
		chk("drop any angle", 32'h1, 32'(outputDrop));
		wr(OFF_VOLT, v);
		repeat (4) @(posedge clk);
		ponRelay <= 1'b1;
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk("pon relay", OFF_CTRL, 32'h1);
		final_report();
	end
endmodule : tb_aodp_top
bind aodp_top aodp_properties #(.TICK_CYCLES(TICK_CYCLES)) u_aodp_properties (
	.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ponRelay(ponRelay),
	.waveQuadrant(waveQuadrant), .relayClose(relayClose),
	.outVoltage(outVoltage), .outputDrop(outputDrop), .outFreq(outFreq),
	.displaySelect(displaySelect), .irq(irq));
`default_nettype wire
